// File: gauge_driver.sv
// serial input, latch, coil drive and status logic of the gauge driver
// Behaviour
// - serial input sampled on each rising serial clock edge into shift register
// - serial output changes on each falling serial clock edge
// - shifting only while select is high; host holds it high throughout
// - select falling edge copies shift register into the drive latch
// - select falling edge clears fault disable and re-enables drivers unless a fault is still present
// - output enable low switches off coil buffers; serial logic keeps running
// - status pulled low while outputs disabled by enable or protection
// - previous 10-bit word shifts out while new word shifts in
// - reset clears all internal registers and latches except fault disable, which reset sets
// - within each 45-degree span only one coil value varies
// - first octant sine follows tangent, cosine at full scale
// - second octant sine at full scale, cosine follows complementary tangent
`timescale 1ns/1ps
module gauge_driver
    import gauge_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic SCLK_I,
    input wire logic CS_I,
    input wire logic SI_I,
    input wire logic OE_I,
    input wire logic FAULT_I,
    output logic SO_O,
    output logic OUTPUT_STATE_FLAG_O,
    output logic OUTPUT_STATE_FLAG_OE_O,
    output logic DRIVE_EN_O,
    output logic [gauge_pkg::WORD_W-1:0] CODE_O,
    output logic [gauge_pkg::DRIVE_W-1:0] SIN_MAG_O,
    output logic [gauge_pkg::DRIVE_W-1:0] COS_MAG_O,
    output logic SIN_NEG_O,
    output logic COS_NEG_O
);
    import gauge_pkg::*;

    logic [2:0] sclk_s_q, cs_s_q;
    logic [1:0] si_s_q, oe_s_q, fault_s_q;
    logic sclk_rise, sclk_fall, cs_fall, cs_hi, si_s, oe_s, fault_s;
    logic [WORD_W-1:0] shift_q, code_q;
    logic so_q, fault_dis_q;
    logic [DRIVE_W-1:0] sin_q, cos_q, tan_val;
    logic sin_neg_q, cos_neg_q;
    logic [STEP_W-1:0] lut_step;
    logic [OCT_W-1:0] oct;

    // two stages before any logic reads a pin; third stage feeds the edge finders
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sclk_s_q <= 3'h0;
            cs_s_q <= 3'h0;
            si_s_q <= 2'h0;
            oe_s_q <= 2'h0;
            fault_s_q <= 2'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], SCLK_I};
            cs_s_q <= {cs_s_q[1:0], CS_I};
            si_s_q <= {si_s_q[0], SI_I};
            oe_s_q <= {oe_s_q[0], OE_I};
            fault_s_q <= {fault_s_q[0], FAULT_I};
        end
    end
    assign sclk_rise = sclk_s_q[1] && !sclk_s_q[2];
    assign sclk_fall = !sclk_s_q[1] && sclk_s_q[2];
    assign cs_fall = !cs_s_q[1] && cs_s_q[2];
    assign cs_hi = cs_s_q[1];
    assign si_s = si_s_q[1];
    assign oe_s = oe_s_q[1];
    assign fault_s = fault_s_q[1];

    // msb-first: new bits enter at the bottom, the oldest leaves at the top
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            shift_q <= WORD_RESET;
        end else if (sclk_rise && cs_hi) begin
            shift_q <= {shift_q[WORD_W-2:0], si_s};
        end
    end

    // so always driven; shows the top bit, refreshed only on falling clock
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            so_q <= 1'b0;
        end else if (sclk_fall) begin
            so_q <= shift_q[WORD_W-1];
        end
    end
    assign SO_O = so_q;

    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            code_q <= WORD_RESET;
        end else if (cs_fall) begin
            code_q <= shift_q;
        end
    end
    assign CODE_O = code_q;

    // disabled after power-up until the first select pulse; a live fault wins over the re-arm
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            fault_dis_q <= 1'b1;
        end else if (fault_s) begin
            fault_dis_q <= 1'b1;
        end else if (cs_fall) begin
            fault_dis_q <= 1'b0;
        end
    end

    assign DRIVE_EN_O = oe_s && !fault_dis_q;
    // open-drain status: pull low when disabled, release otherwise
    assign OUTPUT_STATE_FLAG_O = 1'b0;
    assign OUTPUT_STATE_FLAG_OE_O = !DRIVE_EN_O;

    assign oct = code_q[WORD_W-1 -: OCT_W];
    // odd octants run toward the axis, so the step index is mirrored
    assign lut_step = oct[0] ? ~code_q[STEP_W-1:0] : code_q[STEP_W-1:0];

    tan_lut #(
        .STEP_W(STEP_W),
        .DRIVE_W(DRIVE_W)
    ) u_tan (
        .step_i(lut_step),
        .value_o(tan_val)
    );

    // octants 0,3,4,7 vary the sine coil; 1,2,5,6 vary the cosine coil
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sin_q <= DRIVE_RESET;
            cos_q <= DRIVE_RESET;
            sin_neg_q <= 1'b0;
            cos_neg_q <= 1'b0;
        end else begin
            sin_neg_q <= oct[2];
            cos_neg_q <= oct[2] ^ oct[1];
            if (oct[1] ^ oct[0]) begin
                sin_q <= FULL_SCALE;
                cos_q <= tan_val;
            end else begin
                sin_q <= tan_val;
                cos_q <= FULL_SCALE;
            end
        end
    end
    assign SIN_MAG_O = DRIVE_EN_O ? sin_q : DRIVE_RESET;
    assign COS_MAG_O = DRIVE_EN_O ? cos_q : DRIVE_RESET;
    assign SIN_NEG_O = sin_neg_q;
    assign COS_NEG_O = cos_neg_q;

    property p_shift_hold;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        !cs_hi |=> shift_q == $past(shift_q);
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("shift changed with select low");

    property p_shift_in;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (sclk_rise && cs_hi) |=> shift_q[0] == $past(si_s);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in");

    property p_so;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        !sclk_fall |=> $stable(SO_O);
    endproperty
    a_so: assert property (p_so) else $error("serial out moved off falling edge");

    property p_latch;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        cs_fall |=> CODE_O == $past(shift_q);
    endproperty
    a_latch: assert property (p_latch) else $error("code not latched on select fall");

    property p_rearm;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (cs_fall && !fault_s) |=> !fault_dis_q;
    endproperty
    a_rearm: assert property (p_rearm) else $error("drivers not re-armed");

    property p_fault;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        fault_s |=> fault_dis_q ##1 (fault_dis_q || $past(cs_fall));
    endproperty
    a_fault: assert property (p_fault) else $error("fault disable lost");

    property p_oe_off;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        !oe_s |-> SIN_MAG_O == DRIVE_RESET && COS_MAG_O == DRIVE_RESET;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("buffers on with enable low");

    property p_status;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (!oe_s || fault_dis_q) |-> OUTPUT_STATE_FLAG_OE_O;
    endproperty
    a_status: assert property (p_status) else $error("status not low while disabled");

    property p_one_varies;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (sin_q == FULL_SCALE) || (cos_q == FULL_SCALE) || $past(!RESETN_I);
    endproperty
    a_one_varies: assert property (p_one_varies) else $error("both coils vary");

    property p_oct0;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (oct == 3'h0) |=> cos_q == FULL_SCALE;
    endproperty
    a_oct0: assert property (p_oct0) else $error("cosine not full in first octant");

    property p_oct1;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (oct == 3'h1) |=> sin_q == FULL_SCALE;
    endproperty
    a_oct1: assert property (p_oct1) else $error("sine not full in second octant");

    c_transfer: cover property (@(posedge MCLK_I) disable iff (!RESETN_I) sclk_rise && cs_hi);
    c_latch: cover property (@(posedge MCLK_I) disable iff (!RESETN_I) cs_fall);
    c_fault: cover property (@(posedge MCLK_I) disable iff (!RESETN_I) fault_s ##1 cs_fall);
endmodule

// File: gauge_pkg.sv
// shared constants for the serial gauge coil driver
package gauge_pkg;
    localparam int WORD_W = 10;
    localparam int OCT_W = 3;
    localparam int STEP_W = 7;
    localparam int DRIVE_W = 12;
    localparam logic [11:0] FULL_SCALE = 12'hfff;
    localparam logic [9:0] WORD_RESET = 10'h000;
    localparam logic [11:0] DRIVE_RESET = 12'h000;
endpackage

// File: tan_lut.sv
// tangent lookup over one octant, scaled to full scale
`timescale 1ns/1ps
module tan_lut #(
    parameter int STEP_W = 7,
    parameter int DRIVE_W = 12
) (
    input wire logic [STEP_W-1:0] step_i,
    output logic [DRIVE_W-1:0] value_o
);
    localparam int STEPS = 1 << STEP_W;
    localparam real PI_C = 3.14159265358979;
    localparam real SCALE_C = real'((1 << DRIVE_W) - 1);
    // half a step offset gives the centred angle within each code step
    function automatic logic [DRIVE_W-1:0] tan_at(input int idx);
        real ang;
        ang = (real'(idx) + 0.5) * (PI_C / 4.0) / real'(STEPS);
        return DRIVE_W'($rtoi($sin(ang) / $cos(ang) * SCALE_C + 0.5));
    endfunction
    logic [DRIVE_W-1:0] table_c [STEPS];
    generate
        for (genvar g = 0; g < STEPS; g++) begin : g_tab
            assign table_c[g] = tan_at(g);
        end
    endgenerate
    assign value_o = table_c[step_i];
endmodule

// File: host_model.sv
// host side model: shifts one word out over the serial link per request
`timescale 1ns/1ps
module host_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [9:0] word_i,
    output logic cs_o,
    output logic sclk_o,
    output logic si_o,
    output logic busy_o
);
    initial begin
        cs_o = 1'b0;
        sclk_o = 1'b0;
        si_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (go_i) begin
                busy_o <= 1'b1;
                cs_o <= 1'b1;
                for (int k = 9; k >= 0; k--) begin
                    si_o <= word_i[k];
                    repeat (13) @(posedge clk_i);
                    sclk_o <= 1'b1;
                    repeat (12) @(posedge clk_i);
                    sclk_o <= 1'b0;
                end
                repeat (13) @(posedge clk_i);
                cs_o <= 1'b0;
                // data line no longer valid once the frame is over
                si_o <= ~si_o;
                repeat (2) @(posedge clk_i);
                busy_o <= 1'b0;
            end
        end
    end
endmodule

// File: gauge_driver_tb_top.sv
// self-checking bench for the gauge driver with a host link model
`timescale 1ns/1ps
module gauge_driver_tb_top;
    import gauge_pkg::*;
    logic clk = 0, rst_n = 0, oe = 0, fault = 0, go = 0;
    logic [9:0] word = 0, prev = 0, code;
    logic so, flag, flag_oe, den, sin_neg, cos_neg;
    logic [11:0] sin_m, cos_m;
    logic [31:0] seed = 32'h3ccf, r;
    logic cs, sclk, si, busy;
    int miscompares = 0, n_tests = 0, cycles = 0;
    logic [10:0] note_q[$];
    logic so_q[$];

    always #2.5 clk = ~clk;

    host_model u_host (.clk_i(clk), .go_i(go), .word_i(word), .cs_o(cs), .sclk_o(sclk),
        .si_o(si), .busy_o(busy));
    gauge_driver u_dut (.MCLK_I(clk), .RESETN_I(rst_n), .SCLK_I(sclk), .CS_I(cs), .SI_I(si),
        .OE_I(oe), .FAULT_I(fault), .SO_O(so), .OUTPUT_STATE_FLAG_O(flag),
        .OUTPUT_STATE_FLAG_OE_O(flag_oe), .DRIVE_EN_O(den), .CODE_O(code),
        .SIN_MAG_O(sin_m), .COS_MAG_O(cos_m),
        .SIN_NEG_O(sin_neg), .COS_NEG_O(cos_neg));

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // expected serial-out bits follow a plain shift of the previous word
    task send(input logic [9:0] w, input logic en);
        logic [9:0] m;
        note_q.push_back({en, w});
        m = prev;
        for (int k = 9; k >= 0; k--) begin
            m = {m[8:0], w[k]};
            so_q.push_back(m[9]);
        end
        prev = w;
        @(posedge clk);
        word <= w;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        while (busy) @(posedge clk);
        repeat (10) @(posedge clk);
    endtask

    // the pins settle from unknown at time zero; only edges inside a frame count
    always @(negedge sclk) begin
        if (busy === 1'b1) begin
            repeat (7) @(posedge clk);
            check(so_q.size() > 0 && so === so_q.pop_front(), "serial out bit");
        end
    end

    always @(negedge cs) begin : latch_mon
        logic [10:0] n;
        logic [2:0] oc;
        real ang, t;
        int e;
        if (busy === 1'b1) begin
            repeat (8) @(posedge clk);
            n = note_q.pop_front();
            oc = n[9:7];
            // the varying coil carries the smaller of |tan| and |cot| of the centred angle
            ang = (real'(n[9:0]) + 0.5) * 3.14159265358979 / 512.0;
            t = $sin(ang) / $cos(ang);
            if (t < 0.0)
                t = -t;
            if (t > 1.0)
                t = 1.0 / t;
            e = $rtoi(t * real'(FULL_SCALE) + 0.5);
            check(code === n[9:0], "latched code");
            check(den === n[10] && flag_oe === ~n[10], "drive enable");
            if (n[10]) begin
                check(sin_neg === oc[2] && cos_neg === (oc[2] ^ oc[1]), "polarity");
                if (~(oc[1] ^ oc[0])) begin
                    check(cos_m === FULL_SCALE && sin_m !== FULL_SCALE, "sine varies");
                    check(int'(sin_m) <= e + 1 && int'(sin_m) + 1 >= e, "sine value");
                end else begin
                    check(sin_m === FULL_SCALE && cos_m !== FULL_SCALE, "cosine varies");
                    check(int'(cos_m) <= e + 1 && int'(cos_m) + 1 >= e, "cosine value");
                end
            end else
                check(sin_m === 12'h000 && cos_m === 12'h000, "coils off");
        end
    end

    // ceiling far above the roughly 2800 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict;
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        oe <= 1'b1;
        repeat (4) @(posedge clk);
        check(flag_oe === 1'b1 && den === 1'b0 && flag === 1'b0, "reset state");
        for (int i = 0; i < 8; i++) begin
            r = xs();
            send({i[2:0], r[6:0]}, 1'b1);
        end
        oe <= 1'b0;
        repeat (6) @(posedge clk);
        check(den === 1'b0 && flag_oe === 1'b1 && sin_m === 12'h000, "oe low");
        oe <= 1'b1;
        repeat (6) @(posedge clk);
        check(den === 1'b1 && flag_oe === 1'b0, "oe high");
        fault <= 1'b1;
        repeat (6) @(posedge clk);
        fault <= 1'b0;
        repeat (6) @(posedge clk);
        check(den === 1'b0 && flag_oe === 1'b1, "fault latched");
        r = xs();
        send(r[9:0], 1'b1);
        fault <= 1'b1;
        r = xs();
        send(r[9:0], 1'b0);
        fault <= 1'b0;
        repeat (10) @(posedge clk);
        // a reset in mid-run must clear the latched code and disarm the drivers again
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check(code === 10'h000 && so === 1'b0, "reset clears code");
        check(den === 1'b0 && flag_oe === 1'b1, "reset disarms");
        give_verdict;
    end
endmodule
